/* logic/mdv_map.svh */
`ifndef MDV_MAP_SVH
`define MDV_MAP_SVH

// -----------------------------------------------------------------
// Register addresses on the core's register access port
// -----------------------------------------------------------------
`define MDV_OFF_HIGH 16'hfe0c
`define MDV_OFF_LOW 16'hfe0e
`define MDV_OFF_CTRL 16'hff0e
`define MDV_OFF_ZERO 16'hff1c
`define MDV_OFF_ALLSET 16'hff1e

// -----------------------------------------------------------------
// Field layout and reset values
// -----------------------------------------------------------------
`define MDV_CTRL_RESET 16'h0000
`define MDV_FLAG_BIT 4'h4
`define MDV_SEQ_RESET 7'h00
`define MDV_SEQ_ONE 7'h01
`define MDV_HALF_RESET 16'h0000
`define MDV_ZERO_VAL 16'h0000
`define MDV_ALLSET_VAL 16'hffff

// -----------------------------------------------------------------
// Controller registers on APB (byte offsets)
// -----------------------------------------------------------------
`define MDV_APB_ADDR 8'h00
`define MDV_APB_WDATA 8'h04
`define MDV_APB_CMD 8'h08
`define MDV_APB_RESULT 8'h0c
`define MDV_APB_OPLEN 8'h10
`define MDV_APB_STATUS 8'h14
`define MDV_OPLEN_RESET 4'h1
`define MDV_OPLEN_ONE 4'h1
`define MDV_WORD_ZERO 32'h00000000

`endif

/* logic/mdv_pkg.sv */
`default_nettype none
package mdv_pkg;
	// Which register an access addresses
	typedef enum logic [2:0] {
		MDV_SEL_NONE = 3'b000,
		MDV_SEL_HIGH = 3'b001,
		MDV_SEL_LOW = 3'b010,
		MDV_SEL_CTRL = 3'b011,
		MDV_SEL_ZERO = 3'b100,
		MDV_SEL_ALLSET = 3'b101
	} mdv_sel_t;

	// Kind of arithmetic instruction in flight
	typedef enum logic {
		MDV_KIND_MUL = 1'b0,
		MDV_KIND_DIV = 1'b1
	} mdv_kind_t;

	// Controller command codes
	typedef enum logic [2:0] {
		MDV_CMD_NONE = 3'b000,
		MDV_CMD_WRITE = 3'b001,
		MDV_CMD_READ = 3'b010,
		MDV_CMD_BITWR = 3'b011,
		MDV_CMD_MUL = 3'b100,
		MDV_CMD_DIV = 3'b101
	} mdv_cmd_t;

	// Controller sequencing
	typedef enum logic [1:0] {
		MDV_ST_IDLE = 2'b00,
		MDV_ST_ACC = 2'b01,
		MDV_ST_WAIT = 2'b10,
		MDV_ST_OP = 2'b11
	} mdv_state_t;
endpackage
`default_nettype wire

/* logic/mdv_if.sv */
`default_nettype none
interface mdv_if
	import mdv_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn
);
	// Register access from the core
	logic acc_req;
	logic acc_wr;
	logic acc_bit;
	logic [15:0] acc_addr;
	logic [15:0] acc_wdata;
	logic [3:0] acc_bidx;
	logic acc_bval;
	logic [15:0] acc_rdata;
	logic acc_rvalid;
	// Instruction execution from the core
	logic op_cycle;
	logic op_done;
	mdv_kind_t op_kind;
	logic [15:0] res_hi;
	logic [15:0] res_lo;

	modport dev (
		input pclk, presetn, acc_req, acc_wr, acc_bit, acc_addr,
		input acc_wdata, acc_bidx, acc_bval, op_cycle, op_done,
		input op_kind, res_hi, res_lo,
		output acc_rdata, acc_rvalid
	);
	modport core (
		input pclk, presetn, acc_rdata, acc_rvalid,
		output acc_req, acc_wr, acc_bit, acc_addr, acc_wdata,
		output acc_bidx, acc_bval, op_cycle, op_done, op_kind,
		output res_hi, res_lo
	);
endinterface
`default_nettype wire

/* logic/mdv_seq_cnt.sv */
`default_nettype none
`include "mdv_map.svh"
module mdv_seq_cnt (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clear,
	input wire logic step,
	input wire logic load,
	input wire logic [6:0] load_val,
	output var logic [6:0] seq_reg
);
	// ---------------------------------------------------------------
	// Internal sequencing state
	// ---------------------------------------------------------------
	// Completion wins over stepping, stepping over a software load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_reg <= `MDV_SEQ_RESET;
		end else if (clear) begin
			seq_reg <= `MDV_SEQ_RESET;
		end else if (step) begin
			seq_reg <= seq_reg + `MDV_SEQ_ONE;
		end else if (load) begin
			seq_reg <= load_val;
		end
	end
endmodule
`default_nettype wire

/* logic/mdv_dev.sv */
`default_nettype none
`include "mdv_map.svh"
// Function
// - Product upper half goes to high half
// - Product lower half goes to low half
// - Software loads dividend halves before division
// - Division remainder left in high half
// - Division quotient left in low half
// - Halves form one 32-bit word, low=15:0
// - Software write of either half sets flag
// - Any arithmetic instruction sets the flag
// - Reading low half clears flag, high not
// - Control 16-bit, bit addressable, reset zero
// - Sequencing bits update every instruction cycle
// - Software saves halves and control when nesting
// - Software clears control, restores after nested op
// - Software changes sequencing bits only by save/restore
// - Read-only register always reads all zeros
// - Read-only register always reads all set
module mdv_dev
	import mdv_pkg::*;
(
	mdv_if.dev bus,
	output logic [31:0] working_word,
	output logic working_reg_in_use_flag,
	output logic [15:0] control_word
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Address decode, shared by reads, writes and bit writes
	function automatic mdv_sel_t decode(input logic [15:0] a);
		mdv_sel_t s;
		s = MDV_SEL_NONE;
		if (a == `MDV_OFF_HIGH) begin
			s = MDV_SEL_HIGH;
		end else if (a == `MDV_OFF_LOW) begin
			s = MDV_SEL_LOW;
		end else if (a == `MDV_OFF_CTRL) begin
			s = MDV_SEL_CTRL;
		end else if (a == `MDV_OFF_ZERO) begin
			s = MDV_SEL_ZERO;
		end else if (a == `MDV_OFF_ALLSET) begin
			s = MDV_SEL_ALLSET;
		end
		return s;
	endfunction

	// Control word layout: 15:8 zero, 7:5 and 3:0 sequencing, 4 flag
	function automatic logic [15:0] pack_ctrl(input logic [6:0] q,
			input logic f);
		return {8'h00, q[6:4], f, q[3:0]};
	endfunction

	function automatic logic [6:0] unpack_seq(input logic [15:0] w);
		return {w[7:5], w[3:0]};
	endfunction

	// Single-bit replace used for bit-addressable registers
	function automatic logic [15:0] put_bit(input logic [15:0] w,
			input logic [3:0] i, input logic v);
		logic [15:0] r;
		r = w;
		r[i] = v;
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	logic [15:0] high_reg;
	logic [15:0] low_reg;
	logic flag_reg;
	logic [6:0] seq_reg;
	logic [15:0] rdata_reg;
	logic rvalid_reg;
	mdv_sel_t sel;
	logic word_wr;
	logic bit_wr;
	logic rd;
	logic [15:0] ctrl_now;
	logic [15:0] ctrl_bitwr;
	logic ctrl_load;
	logic [15:0] ctrl_load_val;
	logic flag_set;
	logic flag_clr;

	// Access strobes; constants decode but nothing is ever stored
	assign sel = decode(bus.acc_addr);
	assign word_wr = bus.acc_req & bus.acc_wr & ~bus.acc_bit;
	assign bit_wr = bus.acc_req & bus.acc_wr & bus.acc_bit;
	assign rd = bus.acc_req & ~bus.acc_wr;

	assign ctrl_now = pack_ctrl(seq_reg, flag_reg);
	assign ctrl_bitwr = put_bit(ctrl_now, bus.acc_bidx, bus.acc_bval);

	// Software load of the control word, whole or one bit
	always_comb begin
		ctrl_load = 1'b0;
		ctrl_load_val = ctrl_now;
		if (word_wr && sel == MDV_SEL_CTRL) begin
			ctrl_load = 1'b1;
			ctrl_load_val = bus.acc_wdata;
		end else if (bit_wr && sel == MDV_SEL_CTRL) begin
			ctrl_load = 1'b1;
			ctrl_load_val = ctrl_bitwr;
		end
	end

	// ---------------------------------------------------------------
	// Working register halves
	// ---------------------------------------------------------------
	// A finishing instruction owns the halves in its last cycle; a
	// software write in that same cycle is lost, as the core would
	// never issue both at once
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			high_reg <= `MDV_HALF_RESET;
		end else if (bus.op_done) begin
			// Product upper half, or remainder after a division
			high_reg <= bus.res_hi;
		end else if (word_wr && sel == MDV_SEL_HIGH) begin
			high_reg <= bus.acc_wdata;
		end
	end

	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			low_reg <= `MDV_HALF_RESET;
		end else if (bus.op_done) begin
			// Product lower half, or quotient after a division
			low_reg <= bus.res_lo;
		end else if (word_wr && sel == MDV_SEL_LOW) begin
			low_reg <= bus.acc_wdata;
		end
	end

	// Halves are not bit addressable, so bit writes to them are dropped
	assign working_word = {high_reg, low_reg};

	// ---------------------------------------------------------------
	// In-use flag
	// ---------------------------------------------------------------
	assign flag_set = (word_wr &&
		(sel == MDV_SEL_HIGH || sel == MDV_SEL_LOW)) ||
		bus.op_cycle || bus.op_done;
	assign flag_clr = rd && sel == MDV_SEL_LOW;

	// Set beats clear so an event in the clearing cycle is kept
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			flag_reg <= 1'b0;
		end else if (flag_set) begin
			flag_reg <= 1'b1;
		end else if (ctrl_load) begin
			flag_reg <= ctrl_load_val[`MDV_FLAG_BIT];
		end else if (flag_clr) begin
			flag_reg <= 1'b0;
		end
	end

	assign working_reg_in_use_flag = flag_reg;

	// ---------------------------------------------------------------
	// Sequencing state
	// ---------------------------------------------------------------
	// Software may save, clear and restore these bits; anything else
	// breaks resumption of an interrupted instruction
	mdv_seq_cnt u_seq (
		.pclk(bus.pclk),
		.presetn(bus.presetn),
		.clear(bus.op_done),
		.step(bus.op_cycle),
		.load(ctrl_load),
		.load_val(unpack_seq(ctrl_load_val)),
		.seq_reg(seq_reg)
	);

	assign control_word = ctrl_now;

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Data appears one cycle after the request; unmapped reads zero
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			rdata_reg <= `MDV_ZERO_VAL;
		end else if (rd) begin
			if (sel == MDV_SEL_HIGH) begin
				rdata_reg <= high_reg;
			end else if (sel == MDV_SEL_LOW) begin
				rdata_reg <= low_reg;
			end else if (sel == MDV_SEL_CTRL) begin
				rdata_reg <= ctrl_now;
			end else if (sel == MDV_SEL_ALLSET) begin
				rdata_reg <= `MDV_ALLSET_VAL;
			end else begin
				rdata_reg <= `MDV_ZERO_VAL;
			end
		end
	end

	// One-cycle answer strobe for every read, mapped or not
	always_ff @(posedge bus.pclk or negedge bus.presetn) begin
		if (!bus.presetn) begin
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= rd;
		end
	end

	assign bus.acc_rdata = rdata_reg;
	assign bus.acc_rvalid = rvalid_reg;
endmodule
`default_nettype wire

/* logic/mdv_ctl.sv */
// The APB slave port was chosen for this implementation.
`default_nettype none
`include "mdv_map.svh"
module mdv_ctl
	import mdv_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	mdv_if.core bus
);
	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	logic [20:0] addr_reg;
	logic [15:0] wdata_reg;
	logic [31:0] result_reg;
	logic [3:0] oplen_reg;
	logic [15:0] rback_reg;
	logic [3:0] cnt_reg;
	mdv_state_t state_reg;
	logic req_reg, wr_reg, bit_reg, cyc_reg, done_reg;
	mdv_kind_t kind_reg;
	logic setup, take, busy;
	mdv_cmd_t cmd;

	assign setup = psel & ~penable;
	assign take = psel & penable & pready & pwrite;
	assign busy = state_reg != MDV_ST_IDLE;
	assign cmd = mdv_cmd_t'(pwdata[2:0]);

	// Zero-wait access: ready and read data are set up in the setup
	// cycle so they can come straight from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `MDV_WORD_ZERO;
		end else begin
			pready <= setup;
			pslverr <= 1'b0;
			if (!setup) begin
				prdata <= `MDV_WORD_ZERO;
			end else if (paddr == `MDV_APB_ADDR) begin
				prdata <= {11'h000, addr_reg};
			end else if (paddr == `MDV_APB_WDATA) begin
				prdata <= {16'h0000, wdata_reg};
			end else if (paddr == `MDV_APB_RESULT) begin
				prdata <= result_reg;
			end else if (paddr == `MDV_APB_OPLEN) begin
				prdata <= {28'h0000000, oplen_reg};
			end else if (paddr == `MDV_APB_STATUS) begin
				prdata <= {rback_reg, 15'h0000, busy};
			end else begin
				prdata <= `MDV_WORD_ZERO;
			end
		end
	end

	// Plain setting registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_reg <= 21'h000000;
			wdata_reg <= 16'h0000;
			result_reg <= `MDV_WORD_ZERO;
			oplen_reg <= `MDV_OPLEN_RESET;
		end else if (take) begin
			if (paddr == `MDV_APB_ADDR) begin
				addr_reg <= pwdata[20:0];
			end else if (paddr == `MDV_APB_WDATA) begin
				wdata_reg <= pwdata[15:0];
			end else if (paddr == `MDV_APB_RESULT) begin
				result_reg <= pwdata;
			end else if (paddr == `MDV_APB_OPLEN) begin
				oplen_reg <= pwdata[3:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Core-side sequencer
	// ---------------------------------------------------------------
	// Commands while busy are dropped; software polls the busy bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= MDV_ST_IDLE;
			req_reg <= 1'b0;
			wr_reg <= 1'b0;
			bit_reg <= 1'b0;
			cyc_reg <= 1'b0;
			done_reg <= 1'b0;
			kind_reg <= MDV_KIND_MUL;
			cnt_reg <= `MDV_OPLEN_RESET;
			rback_reg <= 16'h0000;
		end else begin
			case (state_reg)
				MDV_ST_IDLE: begin
					done_reg <= 1'b0;
					if (take && paddr == `MDV_APB_CMD) begin
						if (cmd == MDV_CMD_WRITE || cmd == MDV_CMD_READ ||
								cmd == MDV_CMD_BITWR) begin
							req_reg <= 1'b1;
							wr_reg <= cmd != MDV_CMD_READ;
							bit_reg <= cmd == MDV_CMD_BITWR;
							state_reg <= MDV_ST_ACC;
						end else if (cmd == MDV_CMD_MUL ||
								cmd == MDV_CMD_DIV) begin
							cyc_reg <= 1'b1;
							kind_reg <= cmd == MDV_CMD_DIV ? MDV_KIND_DIV :
								MDV_KIND_MUL;
							cnt_reg <= oplen_reg == 4'h0 ? `MDV_OPLEN_ONE :
								oplen_reg;
							state_reg <= MDV_ST_OP;
						end
					end
				end
				MDV_ST_ACC: begin
					req_reg <= 1'b0;
					state_reg <= wr_reg ? MDV_ST_IDLE : MDV_ST_WAIT;
				end
				MDV_ST_WAIT: begin
					if (bus.acc_rvalid) begin
						rback_reg <= bus.acc_rdata;
						state_reg <= MDV_ST_IDLE;
					end
				end
				MDV_ST_OP: begin
					if (cnt_reg == `MDV_OPLEN_ONE) begin
						cyc_reg <= 1'b0;
						done_reg <= 1'b1;
						state_reg <= MDV_ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - `MDV_OPLEN_ONE;
					end
				end
				default: begin
					state_reg <= MDV_ST_IDLE;
				end
			endcase
		end
	end

	// save, clear and restore are software sequences
	// built from these single accesses
	assign bus.acc_req = req_reg;
	assign bus.acc_wr = wr_reg;
	assign bus.acc_bit = bit_reg;
	assign bus.acc_addr = addr_reg[15:0];
	assign bus.acc_bidx = addr_reg[19:16];
	assign bus.acc_bval = addr_reg[20];
	assign bus.acc_wdata = wdata_reg;
	assign bus.op_cycle = cyc_reg;
	assign bus.op_done = done_reg;
	assign bus.op_kind = kind_reg;
	assign bus.res_hi = result_reg[31:16];
	assign bus.res_lo = result_reg[15:0];
endmodule
`default_nettype wire

/* testbench/mdv_chk.sv */
`default_nettype none
`include "mdv_map.svh"
module mdv_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic acc_req,
	input wire logic acc_wr,
	input wire logic acc_bit,
	input wire logic [15:0] acc_addr,
	input wire logic [15:0] acc_rdata,
	input wire logic acc_rvalid,
	input wire logic op_cycle,
	input wire logic op_done,
	input wire logic [15:0] res_hi,
	input wire logic [15:0] res_lo,
	input wire logic [31:0] working_word,
	input wire logic working_reg_in_use_flag,
	input wire logic [15:0] control_word
);
	timeunit 1ns;
	timeprecision 1ns;
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd_req;
	logic half_wr;
	logic [6:0] seq;
	// Decoded requests; the core port serialises them, so no overlap
	assign rd_req = acc_req && !acc_wr;
	assign half_wr = acc_req && acc_wr && !acc_bit &&
		(acc_addr == `MDV_OFF_HIGH || acc_addr == `MDV_OFF_LOW);
	assign seq = {control_word[7:5], control_word[3:0]};

	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	a_read_answer: assert property (rd_req |=> acc_rvalid)
		else $error("read not answered next cycle");
	a_zero_const: assert property (
		rd_req && acc_addr == `MDV_OFF_ZERO |=> acc_rdata == `MDV_ZERO_VAL)
		else $error("zero constant read wrong");
	a_allset_const: assert property (
		rd_req && acc_addr == `MDV_OFF_ALLSET |=>
		acc_rdata == `MDV_ALLSET_VAL)
		else $error("all-set constant read wrong");
	a_const_wr_ignored: assert property (
		acc_req && acc_wr && (acc_addr == `MDV_OFF_ZERO ||
		acc_addr == `MDV_OFF_ALLSET) |=>
		$stable(working_word) && $stable(control_word))
		else $error("constant write disturbed state");
	a_result_load: assert property (
		op_done |=> working_word == {$past(res_hi), $past(res_lo)})
		else $error("result not placed in halves");
	a_flag_half_wr: assert property (
		half_wr |=> working_reg_in_use_flag)
		else $error("flag not set by half write");
	a_flag_on_op: assert property (
		op_cycle || op_done |=> working_reg_in_use_flag)
		else $error("flag not set by instruction");
	a_flag_low_rd: assert property (
		rd_req && acc_addr == `MDV_OFF_LOW && !op_cycle && !op_done
		|=> !working_reg_in_use_flag)
		else $error("flag not cleared by low read");
	a_flag_high_rd: assert property (
		rd_req && acc_addr == `MDV_OFF_HIGH && working_reg_in_use_flag
		|=> working_reg_in_use_flag)
		else $error("flag cleared by high read");
	a_ctrl_layout: assert property (
		control_word[15:8] == 8'h00 &&
		control_word[4] == working_reg_in_use_flag)
		else $error("control word layout wrong");
	a_seq_step: assert property (
		op_cycle |=> seq == $past(seq) + 7'h01)
		else $error("sequencing state did not step");
	a_seq_clear: assert property (op_done |=> seq == 7'h00)
		else $error("sequencing state not cleared");
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
`include "mdv_map.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic [31:0] working_word;
	logic working_reg_in_use_flag;
	logic [15:0] control_word;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	logic [15:0] hi_m, lo_m, sv_h, sv_l, sv_c, v, a;
	logic [31:0] r, rs, dv;
	logic pslverr;
	logic slv;

	// Clock; the counter cuts a hang short
	always #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			end_of_test();
		end
	end

	mdv_if bus (.pclk(pclk), .presetn(presetn));
	mdv_ctl mdv_ctl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bus(bus));
	mdv_dev mdv_dev_i (.bus(bus), .working_word(working_word),
		.working_reg_in_use_flag(working_reg_in_use_flag),
		.control_word(control_word));
	mdv_chk mdv_chk_i (.pclk(pclk), .presetn(presetn),
		.acc_req(bus.acc_req), .acc_wr(bus.acc_wr), .acc_bit(bus.acc_bit),
		.acc_addr(bus.acc_addr), .acc_rdata(bus.acc_rdata),
		.acc_rvalid(bus.acc_rvalid), .op_cycle(bus.op_cycle),
		.op_done(bus.op_done), .res_hi(bus.res_hi), .res_lo(bus.res_lo),
		.working_word(working_word),
		.working_reg_in_use_flag(working_reg_in_use_flag),
		.control_word(control_word));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			err_total = err_total + 1;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; a spare edge at the end keeps strobes apart
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Controller command, then poll busy; status keeps last read data
	task automatic op(input logic [2:0] c, input logic [15:0] ad,
		input logic [15:0] d, input logic [4:0] b);
		apb(1'b1, `MDV_APB_ADDR, {11'h000, b, ad});
		apb(1'b1, `MDV_APB_WDATA, {16'h0000, d});
		apb(1'b1, `MDV_APB_CMD, {29'h00000000, c});
		r = 32'h00000001;
		while (r[0] !== 1'b0) apb(1'b0, `MDV_APB_STATUS, 32'h00000000);
		v = r[31:16];
	endtask

	task automatic wr(input logic [15:0] ad, input logic [15:0] d);
		op(3'h1, ad, d, 5'h00);
	endtask

	task automatic rd(input logic [15:0] ad);
		op(3'h2, ad, 16'h0000, 5'h00);
	endtask

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(51437));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`MDV_OFF_CTRL);
		chk("ctrl reset", v, 16'h0000);
		chk("flag reset", working_reg_in_use_flag, 1'b0);
		apb(1'b0, 8'h1c, 32'h00000000);
		chk("unmapped apb", r, 32'h00000000);
		chk("slverr", slv, 1'b0);
		// Halves, flag set by either write, cleared by low read only
		hi_m = 16'($urandom);
		lo_m = 16'($urandom);
		wr(`MDV_OFF_HIGH, hi_m);
		chk("flag hi wr", working_reg_in_use_flag, 1'b1);
		rd(`MDV_OFF_LOW);
		wr(`MDV_OFF_LOW, lo_m);
		chk("flag lo wr", working_reg_in_use_flag, 1'b1);
		chk("word", working_word, {hi_m, lo_m});
		rd(`MDV_OFF_HIGH);
		chk("high rd", v, hi_m);
		chk("flag hi rd", working_reg_in_use_flag, 1'b1);
		rd(`MDV_OFF_LOW);
		chk("low rd", v, lo_m);
		chk("flag lo rd", working_reg_in_use_flag, 1'b0);
		// Constants shrug off word and bit writes
		for (int i = 0; i < 2; i++) begin
			a = (i == 0) ? `MDV_OFF_ZERO : `MDV_OFF_ALLSET;
			wr(a, 16'($urandom));
			op(3'h3, a, 16'h0000, {i == 0, 4'h3});
			rd(a);
			chk("const", v, (i == 0) ? 16'h0000 : 16'hffff);
			chk("const flag", working_reg_in_use_flag, 1'b0);
		end
		// Control: upper byte dropped, bit addressable
		wr(`MDV_OFF_CTRL, 16'h12e5);
		rd(`MDV_OFF_CTRL);
		chk("ctrl word", v, 16'h00e5);
		op(3'h3, `MDV_OFF_CTRL, 16'h0000, 5'h14);
		rd(`MDV_OFF_CTRL);
		chk("ctrl bit", v, 16'h00f5);
		// Nested use: save, clear, run, restore; both kinds, both lengths
		for (int k = 0; k < 2; k++) begin
			hi_m = 16'($urandom) & 16'hfffe;
			lo_m = 16'($urandom);
			wr(`MDV_OFF_HIGH, hi_m);
			wr(`MDV_OFF_LOW, lo_m);
			rd(`MDV_OFF_HIGH);
			sv_h = v;
			rd(`MDV_OFF_LOW);
			sv_l = v;
			rd(`MDV_OFF_CTRL);
			sv_c = v;
			chk("saved ctrl", sv_c, 16'h00e5);
			wr(`MDV_OFF_CTRL, 16'h0000);
			apb(1'b1, `MDV_APB_OPLEN, (k == 0) ? 32'h0 : 32'hf);
			// Model result: product, or remainder and quotient; the
			// divisor exceeds the high half so the quotient fits
			dv = {16'h0000, hi_m} + 32'h00000001;
			rs = (k == 0) ? {16'h0000, hi_m} * {16'h0000, lo_m} :
				{16'({hi_m, lo_m} % dv), 16'({hi_m, lo_m} / dv)};
			apb(1'b1, `MDV_APB_RESULT, rs);
			op((k == 0) ? 3'h4 : 3'h5, 16'h0000, 16'($urandom), 5'h00);
			chk("flag op", working_reg_in_use_flag, 1'b1);
			rd(`MDV_OFF_CTRL);
			chk("ctrl after op", v, 16'h0010);
			chk("result", working_word, rs);
			rd(`MDV_OFF_HIGH);
			chk("res high", v, rs[31:16]);
			rd(`MDV_OFF_LOW);
			chk("res low", v, rs[15:0]);
			wr(`MDV_OFF_HIGH, sv_h);
			wr(`MDV_OFF_LOW, sv_l);
			wr(`MDV_OFF_CTRL, sv_c);
			op(3'h3, `MDV_OFF_HIGH, 16'h0000, 5'h10);
			rd(`MDV_OFF_CTRL);
			chk("ctrl restored", v, 16'h00e5);
			rd(`MDV_OFF_HIGH);
			chk("high restored", v, hi_m);
		end
		end_of_test();
	end
endmodule
`default_nettype wire
